/* File: rtl/padc_regs.svh */
// Constants of the pipelined converter output port
`ifndef PADC_REGS_SVH
`define PADC_REGS_SVH
`define PADC_RES_BITS      12
`define PADC_LATENCY       5
`define PADC_RESULT_MSB    11
`define PADC_DUTY_MIN_PCT  35
`define PADC_DUTY_MAX_PCT  65
`define PADC_DUTY_TGT_PCT  50
`define PADC_CLK_NS        4
`define PADC_SAMPLE_RST    12'h000
`endif

/* File: rtl/padc_pkg.sv */
// Types of the pipelined converter output port
package padc_pkg;
    typedef enum logic [1:0] {
        PADC_RUN   = 2'b00,
        PADC_QUASI = 2'b01,
        PADC_STD   = 2'b11
    } padc_power_t;

    typedef struct packed {
        logic fmt_twos;
        logic out_en_n;
        logic clock_duty_adjust;
        logic standard_sleep_pin;
        logic quasi_sleep_pin;
    } padc_ctrl_t;
endpackage : padc_pkg

/* File: rtl/padc_stage.sv */
// One pipeline stage: registers the whole sample word, holding it while hold is high
`timescale 1ns/10ps
`include "padc_regs.svh"
module padc_stage
    import padc_pkg::*;
#(
    parameter int W = `PADC_RES_BITS
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         hold,
    input  wire logic [W-1:0] word_in,
    output logic      [W-1:0] word_out
);
    typedef struct packed {
        logic [W-1:0] word;
    } padc_stage_st_t;

    padc_stage_st_t st_r;
    padc_stage_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!hold) begin
            st_nxt.word = word_in;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign word_out = st_r.word;
endmodule : padc_stage

/* File: rtl/padc_top.sv */
// Digital output port of a 12-bit pipelined converter
`timescale 1ns/10ps
`include "padc_regs.svh"
module padc_top
    import padc_pkg::*;
#(
    parameter int RES_BITS = `PADC_RES_BITS,
    parameter int LATENCY  = `PADC_LATENCY
) (
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire logic [RES_BITS-1:0] sample_in,
    input  wire logic                fmt_twos_pin,
    input  wire logic                out_en_n_pin,
    input  wire logic                clock_duty_adjust,
    input  wire logic                standard_sleep_pin,
    input  wire logic                quasi_sleep_pin,
    output logic      [RES_BITS-1:0] data_out,
    output logic      [RES_BITS-1:0] data_oe_n,
    output logic                     duty_fix_on,
    output logic                     power_std,
    output logic                     power_quasi,
    output logic                     data_valid
);
    // Format logic is fixed to the documented width; the chain needs a latency of two, one stage
    if (RES_BITS != `PADC_RES_BITS || LATENCY < 2) begin : g_bad_cfg
        $error("padc_top: unsupported width or latency");
    end

    // Control pins are asynchronous to this clock
    typedef struct packed {
        padc_ctrl_t                  sync1;
        padc_ctrl_t                  sync2;
        logic [RES_BITS-1:0]         dout;
        logic [RES_BITS-1:0]         oe_n;
        logic                        duty;
        padc_power_t                 pwr;
        logic [$clog2(LATENCY+1)-1:0] fill;
        logic                        valid;
        logic                        pstd;
        logic                        pquasi;
    } padc_st_t;

    padc_st_t            st_r;
    padc_st_t            st_nxt;
    padc_ctrl_t          pins;
    logic [RES_BITS-1:0] stage_w [0:LATENCY-2];
    logic [RES_BITS-1:0] stage_d [0:LATENCY-2];
    logic                hold;

    assign pins = '{fmt_twos:           fmt_twos_pin,
                    out_en_n:           out_en_n_pin,
                    clock_duty_adjust:  clock_duty_adjust,
                    standard_sleep_pin: standard_sleep_pin,
                    quasi_sleep_pin:    quasi_sleep_pin};

    function automatic padc_power_t power_of(input padc_ctrl_t c);
        if (c.standard_sleep_pin) begin
            power_of = PADC_STD;
        end else if (c.quasi_sleep_pin) begin
            power_of = PADC_QUASI;
        end else begin
            power_of = PADC_RUN;
        end
    endfunction : power_of

    // Pipeline frozen while asleep; data resumes after refill
    assign hold = (st_r.pwr != PADC_RUN);

    // Stage chain: first stage samples, later ones pass the word on unchanged
    assign stage_d[0] = sample_in;
    genvar g;
    generate
        for (g = 0; g < LATENCY - 1; g++) begin : g_stage
            if (g > 0) begin : g_link
                assign stage_d[g] = stage_w[g-1];
            end
            padc_stage #(.W(RES_BITS)) u_stage (
                .clock    (clock),
                .srst     (srst),
                .hold     (hold),
                .word_in  (stage_d[g]),
                .word_out (stage_w[g])
            );
        end
    endgenerate

    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = pins;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.duty  = st_r.sync2.clock_duty_adjust;
        st_nxt.pwr   = power_of(st_r.sync2);
        st_nxt.pstd   = (st_nxt.pwr == PADC_STD);
        st_nxt.pquasi = (st_nxt.pwr == PADC_QUASI);
        st_nxt.oe_n  = {RES_BITS{st_r.sync2.out_en_n}};
        if (!hold) begin
            // Last stage: format conversion, MSB on the top line
            st_nxt.dout = stage_w[LATENCY-2];
            if (st_r.sync2.fmt_twos) begin
                st_nxt.dout[`PADC_RESULT_MSB] = ~stage_w[LATENCY-2][`PADC_RESULT_MSB];
            end
            if (st_r.fill != LATENCY[$bits(st_r.fill)-1:0]) begin
                st_nxt.fill = st_r.fill + 1'b1;
            end
        end else begin
            st_nxt.fill = '0;
        end
        // Valid drops on the edge that enters sleep, not one later
        st_nxt.valid = !hold && (st_nxt.pwr == PADC_RUN)
                       && (st_nxt.fill == LATENCY[$bits(st_r.fill)-1:0]);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r      <= '0;
            st_r.oe_n <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_out    = st_r.dout;
    assign data_oe_n   = st_r.oe_n;
    assign duty_fix_on = st_r.duty;
    assign power_std   = st_r.pstd;
    assign power_quasi = st_r.pquasi;
    assign data_valid  = st_r.valid;

    // Five-cycle latency with the two's complement pin low, no sleep on any of the five edges
    sequence run_steady_s;
        !hold [*5];
    endsequence

    // Woken pipeline that stays awake long enough to refill
    sequence wake_s;
        hold ##1 !hold [*6];
    endsequence

    property latency_p;
        @(posedge clock) disable iff (srst)
        (run_steady_s ##1 !$past(st_r.sync2.fmt_twos, 1))
            |-> data_out == $past(sample_in, `PADC_LATENCY);
    endproperty

    latency_five_a: assert property (latency_p)
        else $error("result not five clocks after sample");

    msb_line_a: assert property (@(posedge clock) disable iff (srst)
        (run_steady_s ##1 !$past(st_r.sync2.fmt_twos, 1))
            |-> data_out[`PADC_RESULT_MSB] == $past(sample_in[`PADC_RESULT_MSB], `PADC_LATENCY))
        else $error("msb not on the top line");

    format_flip_a: assert property (@(posedge clock) disable iff (srst)
        (!hold && !$past(hold) && $past(st_r.sync2.fmt_twos))
            |-> data_out[`PADC_RESULT_MSB] == ~$past(stage_w[LATENCY-2][`PADC_RESULT_MSB]))
        else $error("two's complement msb not inverted");

    // Pin effects land three edges after the pin moves
    oe_follow_a: assert property (@(posedge clock) disable iff (srst)
        $past(st_r.sync2.out_en_n) |-> &data_oe_n)
        else $error("outputs not released");

    oe_drive_a: assert property (@(posedge clock) disable iff (srst)
        (!$past(srst) && !$past(st_r.sync2.out_en_n)) |-> data_oe_n == '0)
        else $error("outputs not driven");

    // Stabilizer is a status level only; no clock is re-timed here
    duty_pin_a: assert property (@(posedge clock) disable iff (srst)
        clock_duty_adjust [*3] |=> duty_fix_on)
        else $error("stabilizer not enabled");

    duty_off_a: assert property (@(posedge clock) disable iff (srst)
        !clock_duty_adjust [*3] |=> !duty_fix_on)
        else $error("stabilizer on with pin low");

    std_sleep_a: assert property (@(posedge clock) disable iff (srst)
        standard_sleep_pin [*3] |=> power_std && !power_quasi)
        else $error("standard power-down not entered");

    quasi_sleep_a: assert property (@(posedge clock) disable iff (srst)
        (quasi_sleep_pin && !standard_sleep_pin) [*3] |=> power_quasi)
        else $error("quasi power-down not entered");

    run_pins_a: assert property (@(posedge clock) disable iff (srst)
        (!standard_sleep_pin && !quasi_sleep_pin) [*3] |=> !power_std && !power_quasi)
        else $error("power-down not left");

    sleep_hold_a: assert property (@(posedge clock) disable iff (srst)
        (hold && $past(hold)) |-> $stable(data_out) && !data_valid)
        else $error("output changed while asleep");

    // Stage hand-off on every running edge
    stage_take_a: assert property (@(posedge clock) disable iff (srst)
        !hold |=> stage_w[0] == $past(sample_in))
        else $error("sample not taken on clock edge");

    chain_shift_a: assert property (@(posedge clock) disable iff (srst)
        !hold |=> stage_w[LATENCY-2] == $past(stage_d[LATENCY-2]))
        else $error("last stage did not advance");

    // Valid only after a full refill following sleep
    refill_wait_a: assert property (@(posedge clock) disable iff (srst)
        wake_s |-> data_valid && !$past(data_valid))
        else $error("valid not raised after refill");
endmodule : padc_top

/* File: verif/padc_capture.sv */
// Capture-side model: registers one output word per clock while valid and driven
`timescale 1ns/10ps
module padc_capture
    import padc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic [11:0] data_out,
    input  wire logic [11:0] data_oe_n,
    input  wire logic        data_valid,
    output logic      [11:0] cap_word
);
    // Words from before the pipeline refills are dropped
    always_ff @(posedge clock) begin
        if (data_valid && data_oe_n == 12'h000) begin
            cap_word <= data_out;
        end
    end
endmodule : padc_capture

/* File: verif/test_padc_top.sv */
// Self-checking bench of the pipelined converter output port
`timescale 1ns/10ps
module test_padc_top
    import padc_pkg::*;
;
    logic        clock     = 1'b0;
    logic        srst      = 1'b1;
    logic [11:0] sample_in = 12'h000;
    padc_ctrl_t  ctrl      = '0;
    padc_ctrl_t  c;
    logic [11:0] data_out, data_oe_n, cap_word;
    logic        duty_fix_on, power_std, power_quasi, data_valid;
    logic [11:0] hist [0:255];
    int          error_cnt = 0, compares = 0, cycles = 0, n = 0;

    padc_top dut (.clock(clock), .srst(srst), .sample_in(sample_in),
        .fmt_twos_pin(ctrl.fmt_twos), .out_en_n_pin(ctrl.out_en_n),
        .clock_duty_adjust(ctrl.clock_duty_adjust),
        .standard_sleep_pin(ctrl.standard_sleep_pin), .quasi_sleep_pin(ctrl.quasi_sleep_pin),
        .data_out(data_out), .data_oe_n(data_oe_n), .duty_fix_on(duty_fix_on),
        .power_std(power_std), .power_quasi(power_quasi), .data_valid(data_valid));
    padc_capture cap (.clock(clock), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_valid(data_valid), .cap_word(cap_word));

    always #2 clock = ~clock;
    // Ceiling well above the roughly 85 cycles of the sequence
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end

    task check_word(string what, logic [11:0] exp, logic [11:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word
    task check_bit(string what, logic exp, logic got);
        compares = compares + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    function logic [11:0] fmtd(int k, logic twos);
        fmtd = twos ? {~hist[k][11], hist[k][10:0]} : hist[k];
    endfunction : fmtd
    // Controls move only together with a sample edge, as static settings
    task step(int cnt, padc_ctrl_t cc);
        repeat (cnt) begin
            @(posedge clock);
            hist[n] = 12'(n * 419);
            sample_in <= hist[n];
            ctrl <= cc;
            @(negedge clock);
            n = n + 1;
        end
    endtask : step
    task stream(int cnt, padc_ctrl_t cc);
        repeat (cnt) begin
            step(1, cc);
            check_bit("data_valid", 1'b1, data_valid);
            check_word("data_out", fmtd(n - 6, cc.fmt_twos), data_out);
            check_word("cap_word", fmtd(n - 7, cc.fmt_twos), cap_word);
        end
    endtask : stream
    task end_sim();
        $display("Errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    initial begin
        c = '0;
        repeat (4) @(posedge clock);
        @(negedge clock);
        check_word("data_oe_n", 12'hFFF, data_oe_n);
        check_bit("data_valid", 1'b0, data_valid);
        @(posedge clock);
        srst <= 1'b0;
        step(8, c);
        stream(12, c);
        c.fmt_twos = 1'b1;
        step(6, c);
        stream(10, c);
        c.out_en_n = 1'b1;
        step(4, c);
        check_word("data_oe_n", 12'hFFF, data_oe_n);
        c.out_en_n = 1'b0;
        step(4, c);
        check_word("data_oe_n", 12'h000, data_oe_n);
        check_bit("duty_fix_on", 1'b0, duty_fix_on);
        c.clock_duty_adjust = 1'b1;
        step(4, c);
        check_bit("duty_fix_on", 1'b1, duty_fix_on);
        c.clock_duty_adjust = 1'b0;
        c.quasi_sleep_pin = 1'b1;
        step(4, c);
        check_bit("power_quasi", 1'b1, power_quasi);
        check_bit("data_valid", 1'b0, data_valid);
        c.standard_sleep_pin = 1'b1;
        step(4, c);
        check_bit("power_std", 1'b1, power_std);
        check_bit("power_quasi", 1'b0, power_quasi);
        c.standard_sleep_pin = 1'b0;
        c.quasi_sleep_pin = 1'b0;
        step(12, c);
        stream(10, c);
        end_sim();
    end
endmodule : test_padc_top
